// ---- hdl/tic_ana.sv ----
// one analog input channel: normalise, then gain and bias
// assumes adc codes come from logic on the same clock
`timescale 1ns/1ps
module tic_ana
    import tic_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    input  wire logic [tic_pkg::ADC_W-1:0] code_i,
    input  wire logic [1:0]              range_i,
    input  wire logic signed [15:0]      gain_i,
    input  wire logic signed [15:0]      bias_i,
    output logic signed [15:0]           result_o
);
    logic [29:0]        prod;
    logic [11:0]        code_live;
    logic [10:0]        pct_nxt;
    logic [10:0]        pct_r;
    logic signed [47:0] scaled;
    logic signed [47:0] quot;

    always_comb begin
        code_live = (code_i > LIVE_ZERO) ? code_i - LIVE_ZERO : 12'h000;
        unique case (range_i)
            RNG_5V:   prod = {18'h0, code_i} * K_HALF;
            RNG_4_20: prod = {18'h0, code_live} * K_LIVE;
            default:  prod = {18'h0, code_i} * K_FULL;
        endcase
        // clip above full span of the selected range
        if (prod[29:16] > 14'(PCT_FULL))
            pct_nxt = 11'(PCT_FULL);
        else
            pct_nxt = prod[26:16];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            pct_r <= '0;
        else
            pct_r <= pct_nxt;
    end

    always_comb begin
        scaled = 48'($signed({1'b0, pct_r})) * 48'(gain_i);
        // round toward zero for a symmetric result
        if (scaled < 0)
            quot = -(((-scaled) * 48'(K_DIV1000)) >>> 24);
        else
            quot = (scaled * 48'(K_DIV1000)) >>> 24;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i)
            result_o <= '0;
        else
            result_o <= 16'(quot) + bias_i;
    end
endmodule

// ---- hdl/tic_top.sv ----
// terminal i/o conditioning: digital inputs, analog inputs, digital out
// assumes axi4-lite master on CLK_I, field pins asynchronous
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module tic_top
    import tic_pkg::*;
(
    input  wire logic                      CLK_I,
    input  wire logic                      SRST_I,
    input  wire logic [tic_pkg::DIN_N-1:0] DIN_I,
    output logic                           DIO4_O,
    output logic                           DIO4_OEN_O,
    input  wire logic [tic_pkg::ADC_W-1:0] AIN1_I,
    input  wire logic [tic_pkg::ADC_W-1:0] AIN2_I,
    input  wire logic                      DRV_RUN_I,
    input  wire logic                      DRV_TRIP_I,
    input  wire logic [15:0]               DRV_FREQ_I,
    input  wire logic [15:0]               DRV_MAXSPD_I,
    input  wire logic [15:0]               DRV_SETPT_I,
    input  wire logic signed [15:0]        DRV_TORQUE_I,
    input  wire logic [7:0]                AWADDR_I,
    input  wire logic                      AWVALID_I,
    output logic                           AWREADY_O,
    input  wire logic [31:0]               WDATA_I,
    input  wire logic [3:0]                WSTRB_I,
    input  wire logic                      WVALID_I,
    output logic                           WREADY_O,
    output logic [1:0]                     BRESP_O,
    output logic                           BVALID_O,
    input  wire logic                      BREADY_I,
    input  wire logic [7:0]                ARADDR_I,
    input  wire logic                      ARVALID_I,
    output logic                           ARREADY_O,
    output logic [31:0]                    RDATA_O,
    output logic [1:0]                     RRESP_O,
    output logic                           RVALID_O,
    input  wire logic                      RREADY_I
);
    logic [DIN_N-1:0]   din_meta_r;
    logic [DIN_N-1:0]   din_sync_r;
    logic [DIN_N-1:0]   din_inv_r;
    logic [DIN_N-1:0]   din_val_r;
    logic signed [15:0] a1_gain_r;
    logic signed [15:0] a1_bias_r;
    logic signed [15:0] a2_gain_r;
    logic signed [15:0] a2_bias_r;
    logic [1:0]         a1_range_r;
    logic [1:0]         a2_range_r;
    logic signed [15:0] a1_result;
    logic signed [15:0] a2_result;
    logic [2:0]         dout_src_r;
    logic               dout_inv_r;
    logic               dout_val_r;
    logic [15:0]        trq_lvl_r;
    logic               src_bit;
    logic [23:0]        freq_x100;
    logic [16:0]        freq_err;
    logic [23:0]        err_x100;
    logic [15:0]        trq_mag;

    logic [7:0]  aw_addr_r;
    logic        aw_full_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_full_r;
    logic        do_wr;
    logic        wr_hit;
    logic        aw_full_nxt;
    logic        w_full_nxt;
    logic        rvalid_nxt;
    logic [31:0] rd_word;
    logic        rd_hit;

    // byte-lane merge of a write into a 16-bit field
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] m;
        m = old;
        if (strb[0])
            m[7:0] = data[7:0];
        if (strb[1])
            m[15:8] = data[15:8];
        return m;
    endfunction

    // clamp a signed percentage setting to its span
    function automatic logic [15:0] clamp_pct(input logic [15:0] v);
        logic signed [15:0] s;
        s = $signed(v);
        if (s > PCT_LIMIT)
            return PCT_LIMIT;
        else if (s < -PCT_LIMIT)
            return -PCT_LIMIT;
        return v;
    endfunction

    // ---------------- digital inputs
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            din_meta_r <= '0;
            din_sync_r <= '0;
        end else begin
            din_meta_r <= DIN_I;
            din_sync_r <= din_meta_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DIN_N; gi++) begin : g_din
            always_ff @(posedge CLK_I) begin
                if (SRST_I)
                    din_val_r[gi] <= 1'b0;
                else
                    din_val_r[gi] <= din_sync_r[gi] ^ din_inv_r[gi];
            end
        end
    endgenerate

    // ---------------- analog inputs
    tic_ana u_ana1 (
        .clk_i    (CLK_I),
        .srst_i   (SRST_I),
        .code_i   (AIN1_I),
        .range_i  (a1_range_r),
        .gain_i   (a1_gain_r),
        .bias_i   (a1_bias_r),
        .result_o (a1_result)
    );

    tic_ana u_ana2 (
        .clk_i    (CLK_I),
        .srst_i   (SRST_I),
        .code_i   (AIN2_I),
        .range_i  (a2_range_r),
        .gain_i   (a2_gain_r),
        .bias_i   (a2_bias_r),
        .result_o (a2_result)
    );

    // ---------------- drive status sources and digital output
    always_comb begin
        freq_x100 = 24'(DRV_FREQ_I) * 24'h64;
        freq_err  = (DRV_FREQ_I > DRV_SETPT_I) ?
                    17'(DRV_FREQ_I - DRV_SETPT_I) :
                    17'(DRV_SETPT_I - DRV_FREQ_I);
        err_x100  = 24'(freq_err) * 24'h64;
        trq_mag   = DRV_TORQUE_I[15] ? 16'(-DRV_TORQUE_I) :
                    16'(DRV_TORQUE_I);
        unique case (tic_src_e'(dout_src_r))
            SRC_NONE:     src_bit = 1'b0;
            SRC_HEALTH:   src_bit = !DRV_RUN_I || !DRV_TRIP_I;
            SRC_TRIPPED:  src_bit = DRV_TRIP_I;
            SRC_RUNNING:  src_bit = DRV_RUN_I;
            SRC_ZERO:     src_bit = freq_x100 < 24'(DRV_MAXSPD_I);
            SRC_SETPOINT: src_bit = err_x100 <= 24'(DRV_MAXSPD_I);
            SRC_TORQUE:   src_bit = trq_mag >= trq_lvl_r;
            default:      src_bit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dout_val_r <= 1'b0;
            DIO4_O     <= 1'b0;
            DIO4_OEN_O <= 1'b1;
        end else begin
            dout_val_r <= src_bit ^ dout_inv_r;
            DIO4_O     <= src_bit ^ dout_inv_r;
            DIO4_OEN_O <= (dout_src_r == SRC_NONE) && !dout_inv_r;
        end
    end

    // ---------------- axi4-lite write path
    assign do_wr       = aw_full_r && w_full_r && !BVALID_O;
    assign aw_full_nxt = (aw_full_r || (AWVALID_I && AWREADY_O)) && !do_wr;
    assign w_full_nxt  = (w_full_r || (WVALID_I && WREADY_O)) && !do_wr;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            AWREADY_O <= 1'b0;
            WREADY_O  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            AWREADY_O <= !aw_full_nxt;
            WREADY_O  <= !w_full_nxt;
            if (AWVALID_I && AWREADY_O)
                aw_addr_r <= AWADDR_I;
            if (WVALID_I && WREADY_O) begin
                w_data_r <= WDATA_I;
                w_strb_r <= WSTRB_I;
            end
        end
    end

    always_comb begin
        unique case ({aw_addr_r[7:2], 2'b00})
            OFS_DIN_INV, OFS_A1_GAIN, OFS_A1_BIAS, OFS_A1_RANGE,
            OFS_A2_GAIN, OFS_A2_BIAS, OFS_A2_RANGE, OFS_DOUT_SRC,
            OFS_DOUT_INV, OFS_TRQ_LEVEL, OFS_DIN_VAL, OFS_A1_RESULT,
            OFS_A2_RESULT, OFS_DOUT_VAL: wr_hit = 1'b1;
            default:                     wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            BVALID_O <= 1'b0;
            BRESP_O  <= 2'b00;
        end else if (do_wr) begin
            BVALID_O <= 1'b1;
            BRESP_O  <= wr_hit ? 2'b00 : 2'b10;
        end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end

    // settings; out-of-span values are clamped or refused
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            din_inv_r  <= RST_DIN_INV;
            a1_gain_r  <= RST_GAIN;
            a1_bias_r  <= RST_BIAS;
            a2_gain_r  <= RST_GAIN;
            a2_bias_r  <= RST_BIAS;
            a1_range_r <= RST_A1_RANGE;
            a2_range_r <= RST_A2_RANGE;
            dout_src_r <= SRC_NONE;
            dout_inv_r <= 1'b0;
            trq_lvl_r  <= RST_TRQ_LVL;
        end else if (do_wr && w_strb_r[0]) begin
            unique case ({aw_addr_r[7:2], 2'b00})
                OFS_DIN_INV:  din_inv_r <= w_data_r[DIN_N-1:0];
                OFS_A1_GAIN:
                    a1_gain_r <= clamp_pct(merge16(a1_gain_r, w_data_r,
                                                   w_strb_r));
                OFS_A1_BIAS:
                    a1_bias_r <= clamp_pct(merge16(a1_bias_r, w_data_r,
                                                   w_strb_r));
                OFS_A2_GAIN:
                    a2_gain_r <= clamp_pct(merge16(a2_gain_r, w_data_r,
                                                   w_strb_r));
                OFS_A2_BIAS:
                    a2_bias_r <= clamp_pct(merge16(a2_bias_r, w_data_r,
                                                   w_strb_r));
                OFS_A1_RANGE:
                    if (w_data_r[1:0] <= RNG_5V)
                        a1_range_r <= w_data_r[1:0];
                OFS_A2_RANGE: a2_range_r <= w_data_r[1:0];
                OFS_DOUT_SRC:
                    if (w_data_r[2:0] <= SRC_MAX)
                        dout_src_r <= w_data_r[2:0];
                OFS_DOUT_INV: dout_inv_r <= w_data_r[0];
                OFS_TRQ_LEVEL:
                    trq_lvl_r <= merge16(trq_lvl_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end else if (do_wr && w_strb_r[1]) begin
            unique case ({aw_addr_r[7:2], 2'b00})
                OFS_A1_GAIN:
                    a1_gain_r <= clamp_pct(merge16(a1_gain_r, w_data_r,
                                                   w_strb_r));
                OFS_A1_BIAS:
                    a1_bias_r <= clamp_pct(merge16(a1_bias_r, w_data_r,
                                                   w_strb_r));
                OFS_A2_GAIN:
                    a2_gain_r <= clamp_pct(merge16(a2_gain_r, w_data_r,
                                                   w_strb_r));
                OFS_A2_BIAS:
                    a2_bias_r <= clamp_pct(merge16(a2_bias_r, w_data_r,
                                                   w_strb_r));
                OFS_TRQ_LEVEL:
                    trq_lvl_r <= merge16(trq_lvl_r, w_data_r, w_strb_r);
                default: ;
            endcase
        end
    end

    // ---------------- axi4-lite read path
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = '0;
        unique case ({ARADDR_I[7:2], 2'b00})
            OFS_DIN_INV:   rd_word = 32'(din_inv_r);
            OFS_DIN_VAL:   rd_word = 32'(din_val_r);
            OFS_A1_GAIN:   rd_word = 32'(a1_gain_r);
            OFS_A1_BIAS:   rd_word = 32'(a1_bias_r);
            OFS_A1_RANGE:  rd_word = 32'(a1_range_r);
            OFS_A2_GAIN:   rd_word = 32'(a2_gain_r);
            OFS_A2_BIAS:   rd_word = 32'(a2_bias_r);
            OFS_A2_RANGE:  rd_word = 32'(a2_range_r);
            OFS_A1_RESULT: rd_word = 32'($unsigned(a1_result));
            OFS_A2_RESULT: rd_word = 32'($unsigned(a2_result));
            OFS_DOUT_SRC:  rd_word = 32'(dout_src_r);
            OFS_DOUT_INV:  rd_word = 32'(dout_inv_r);
            OFS_DOUT_VAL:  rd_word = 32'(dout_val_r);
            OFS_TRQ_LEVEL: rd_word = 32'(trq_lvl_r);
            default:       rd_hit  = 1'b0;
        endcase
    end

    assign rvalid_nxt = (ARVALID_I && ARREADY_O) || (RVALID_O && !RREADY_I);

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RVALID_O  <= 1'b0;
            ARREADY_O <= 1'b0;
            RDATA_O   <= '0;
            RRESP_O   <= 2'b00;
        end else begin
            RVALID_O  <= rvalid_nxt;
            ARREADY_O <= !rvalid_nxt;
            if (ARVALID_I && ARREADY_O) begin
                RDATA_O <= rd_word;
                RRESP_O <= rd_hit ? 2'b00 : 2'b10;
            end
        end
    end
endmodule

// ---- pkg/tic_pkg.sv ----
// constants for the terminal i/o conditioning block
// assumes a 32-bit axi4-lite register bus and 12-bit adc codes
package tic_pkg;
    localparam int DIN_N = 7;
    localparam int ADC_W = 12;
    localparam int VAL_W = 16;

    // register byte offsets
    localparam logic [7:0] OFS_DIN_INV   = 8'h00;
    localparam logic [7:0] OFS_DIN_VAL   = 8'h04;
    localparam logic [7:0] OFS_A1_GAIN   = 8'h08;
    localparam logic [7:0] OFS_A1_BIAS   = 8'h0c;
    localparam logic [7:0] OFS_A1_RANGE  = 8'h10;
    localparam logic [7:0] OFS_A2_GAIN   = 8'h14;
    localparam logic [7:0] OFS_A2_BIAS   = 8'h18;
    localparam logic [7:0] OFS_A2_RANGE  = 8'h1c;
    localparam logic [7:0] OFS_A1_RESULT = 8'h20;
    localparam logic [7:0] OFS_A2_RESULT = 8'h24;
    localparam logic [7:0] OFS_DOUT_SRC  = 8'h28;
    localparam logic [7:0] OFS_DOUT_INV  = 8'h2c;
    localparam logic [7:0] OFS_DOUT_VAL  = 8'h30;
    localparam logic [7:0] OFS_TRQ_LEVEL = 8'h34;

    // reset values; percentages are in tenths
    localparam logic [6:0] RST_DIN_INV  = 7'h10;
    localparam logic [15:0] RST_GAIN    = 16'h03e8;
    localparam logic [15:0] RST_BIAS    = 16'h0000;
    localparam logic [1:0] RST_A1_RANGE = 2'h0;
    localparam logic [1:0] RST_A2_RANGE = 2'h3;
    localparam logic [15:0] RST_TRQ_LVL = 16'h0000;
    localparam logic signed [15:0] PCT_LIMIT = 16'sh0bb8;
    localparam int PCT_FULL = 1000;

    // analog range codes
    localparam logic [1:0] RNG_10V   = 2'h0;
    localparam logic [1:0] RNG_5V    = 2'h1;
    localparam logic [1:0] RNG_20MA  = 2'h2;
    localparam logic [1:0] RNG_4_20  = 2'h3;

    // normalising constants: code * k >> 16 gives tenths of percent
    localparam logic [17:0] K_FULL   = 18'h03e84;
    localparam logic [17:0] K_HALF   = 18'h07d08;
    localparam logic [17:0] K_LIVE   = 18'h04e25;
    localparam logic [11:0] LIVE_ZERO = 12'h333;
    // divide by 1000 as multiply by 2^24/1000
    localparam logic [15:0] K_DIV1000 = 16'h4189;

    typedef enum logic [2:0] {
        SRC_NONE, SRC_HEALTH, SRC_TRIPPED, SRC_RUNNING,
        SRC_ZERO, SRC_SETPOINT, SRC_TORQUE
    } tic_src_e;
    localparam logic [2:0] SRC_MAX = 3'h6;
endpackage

// ---- tb/terminal_io_conditioning_tb_top.sv ----
// self-checking bench for the terminal i/o conditioning block
// assumes tic_top, the field model and the bound checker are compiled
`timescale 1ns/1ps
module terminal_io_conditioning_tb_top;
    import tic_pkg::*;
    logic               clk, srst, run, trip, dio4, dio4_oen;
    logic [6:0]         sw, din;
    logic [11:0]        a1, a2, ain1, ain2;
    logic [15:0]        freq, maxspd, setp;
    logic signed [15:0] trq;
    logic [7:0]         awaddr, araddr;
    logic               awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic [33:0]        rq[$];
    logic [1:0]         bq[$];
    int                 n_errors = 0;
    int                 n_compared = 0;
    integer             seed = 32'hde0a;
    tic_top dut (
        .CLK_I(clk), .SRST_I(srst), .DIN_I(din), .DIO4_O(dio4),
        .DIO4_OEN_O(dio4_oen), .AIN1_I(ain1), .AIN2_I(ain2),
        .DRV_RUN_I(run), .DRV_TRIP_I(trip), .DRV_FREQ_I(freq),
        .DRV_MAXSPD_I(maxspd), .DRV_SETPT_I(setp), .DRV_TORQUE_I(trq),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready));
    tic_field_model u_field (.clk_i(clk), .sw_i(sw), .a1_i(a1), .a2_i(a2),
        .dio4_i(dio4), .dio4_oe_n_i(dio4_oen), .din_o(din),
        .ain1_o(ain1), .ain2_o(ain2));
    always #25 clk = ~clk;
    function automatic int pct(input int r, input int c);
        case (r)
            1: pct = c * 2000 / 4095;
            3: pct = c < 819 ? 0 : (c - 819) * 1000 / 3276;
            default: pct = c * 1000 / 4095;
        endcase
        if (pct > 1000) pct = 1000;
    endfunction
    function automatic logic st(input int s);
        int df;
        int t;
        df = freq > setp ? freq - setp : setp - freq;
        t = trq;
        case (s)
            1: st = !run || !trip;
            2: st = trip;
            3: st = run;
            4: st = freq * 100 < maxspd;
            5: st = df * 100 <= maxspd;
            6: st = (t < 0 ? -t : t) >= 'h4000;
            default: st = 1'b0;
        endcase
    endfunction
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
        cmp_rd({32'h0, e}, {32'h0, g});
    endtask
    task automatic test_done;
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'h0);
        bq.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        // let an edge pass so a following write never re-drives bready
        @(posedge clk);
    endtask
    // read with one stalled cycle before rready rises
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'h0);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        @(posedge clk);
        rready <= 1'b1;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rvalid && rready) cmp_rd(rq.pop_front(), {rresp, rdata});
        if (bvalid && bready) cmp_wr(bq.pop_front(), bresp);
    end
    initial begin
        #1000000;
        n_errors++;
        test_done;
    end
    initial begin
        logic [7:0] ra[11] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
                               8'h1c, 8'h28, 8'h2c, 8'h30, 8'h04};
        logic [31:0] rv[11] = '{32'h10, 32'h3e8, 32'h0, 32'h0, 32'h3e8,
                                32'h0, 32'h3, 32'h0, 32'h0, 32'h0, 32'h10};
        int rg[7] = '{0, 1, 2, 3, 3, 0, 1};
        int cd[7] = '{2048, 1024, 2048, 2457, 100, 2048, 1024};
        logic [6:0] inv;
        logic [7:0] rb;
        int g;
        int b;
        clk = 1'b0;
        srst = 1'b1;
        {run, trip, sw, a1, a2, freq, maxspd, setp, trq} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h44, 32'h1, 2'h2);
        for (int i = 0; i < 5; i++) begin
            inv = i ? 7'($random(seed)) : 7'h10;
            if (i) wr(OFS_DIN_INV, {25'h0, inv});
            sw <= 7'($random(seed));
            repeat (5) @(posedge clk);
            rd(OFS_DIN_VAL, {25'h0, sw ^ inv});
        end
        for (int i = 0; i < 7; i++) begin
            g = i < 2 ? 999 : -1001;
            b = $random(seed) % 300;
            rb = i < 2 ? OFS_A1_GAIN : OFS_A2_GAIN;
            wr(rb, {16'h0, 16'(g)});
            wr(rb + 8'h4, {16'h0, 16'(b)});
            wr(rb + 8'h8, rg[i]);
            a1 <= 12'(cd[i]);
            a2 <= 12'(cd[i]);
            repeat (5) @(posedge clk);
            rd(i < 2 ? OFS_A1_RESULT : OFS_A2_RESULT,
               {16'h0, 16'(pct(rg[i], cd[i]) * g / 1000 + b)});
        end
        wr(OFS_A1_RANGE, 32'h2);
        rd(OFS_A1_RANGE, 32'h1);
        wr(OFS_A1_GAIN, 32'h0fa0);
        rd(OFS_A1_GAIN, 32'h0bb8);
        wr(OFS_TRQ_LEVEL, 32'h4000);
        for (int s = 0; s < 7; s++) begin
            for (int v = 0; v < 2; v++) begin
                wr(OFS_DOUT_SRC, s);
                wr(OFS_DOUT_INV, v);
                repeat (2) begin
                    {run, trip} <= 2'($random(seed));
                    g = $random(seed) & 'h1ff;
                    freq <= 16'(g);
                    setp <= 16'(g + ($random(seed) & 'h1ff));
                    maxspd <= 16'($random(seed)) | 16'h8000;
                    trq <= 16'($random(seed));
                    repeat (3) @(posedge clk);
                    rd(OFS_DOUT_VAL, {31'h0, st(s) ^ v[0]});
                end
            end
        end
        wr(OFS_DOUT_SRC, 32'h7);
        rd(OFS_DOUT_SRC, 32'h6);
        repeat (2) @(posedge clk);
        test_done;
    end
endmodule

// ---- tb/tic_field_model.sv ----
// field side: switches, analog transmitters, shared terminal 4
// assumes commands from the bench on the rising clock edge
`timescale 1ns/1ps
module tic_field_model
    import tic_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic [tic_pkg::DIN_N-1:0] sw_i,
    input  wire logic [tic_pkg::ADC_W-1:0] a1_i,
    input  wire logic [tic_pkg::ADC_W-1:0] a2_i,
    input  wire logic                      dio4_i,
    input  wire logic                      dio4_oe_n_i,
    output logic      [tic_pkg::DIN_N-1:0] din_o,
    output logic      [tic_pkg::ADC_W-1:0] ain1_o,
    output logic      [tic_pkg::ADC_W-1:0] ain2_o
);
    // transmitters convert once a cycle, one cycle behind
    always_ff @(posedge clk_i) begin
        ain1_o <= a1_i;
        ain2_o <= a2_i;
    end
    // terminal 4 follows the drive while enabled, the switch otherwise
    always_comb begin
        din_o    = sw_i;
        din_o[3] = dio4_oe_n_i ? sw_i[3] : dio4_i;
    end
endmodule

// ---- tb/tic_top_asserts.sv ----
// port checks for the terminal i/o conditioning top
// assumes settings change only at a write response
`timescale 1ns/1ps
module tic_top_asserts
    import tic_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        SRST_I,
    input wire logic        DIO4_O,
    input wire logic        DIO4_OEN_O,
    input wire logic        DRV_RUN_I,
    input wire logic        DRV_TRIP_I,
    input wire logic [15:0] DRV_FREQ_I,
    input wire logic [15:0] DRV_MAXSPD_I,
    input wire logic [7:0]  AWADDR_I,
    input wire logic        AWVALID_I,
    input wire logic        AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0]  WSTRB_I,
    input wire logic        WVALID_I,
    input wire logic        WREADY_O,
    input wire logic [1:0]  BRESP_O,
    input wire logic        BVALID_O,
    input wire logic [31:0] RDATA_O,
    input wire logic        RVALID_O,
    input wire logic        RREADY_I
);
    logic [7:0]  wa_r;
    logic [31:0] wd_r;
    logic        ws_r;
    logic [2:0]  src_r;
    logic        inv_r;
    logic [1:0]  age_r;
    logic        ok;
    default clocking dc @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    always_ff @(posedge CLK_I) begin
        if (AWVALID_I && AWREADY_O) wa_r <= AWADDR_I;
        if (WVALID_I && WREADY_O) wd_r <= WDATA_I;
        if (WVALID_I && WREADY_O) ws_r <= WSTRB_I[0];
    end
    // shadow of the output settings, committed with the response
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            src_r <= 3'h0;
            inv_r <= 1'b0;
        end else if ($rose(BVALID_O) && BRESP_O == 2'h0 && ws_r) begin
            if (wa_r == OFS_DOUT_SRC && wd_r[2:0] <= SRC_MAX)
                src_r <= wd_r[2:0];
            if (wa_r == OFS_DOUT_INV) inv_r <= wd_r[0];
        end
    end
    // settle time after reset or a settings change
    always_ff @(posedge CLK_I) begin
        if (SRST_I || $rose(BVALID_O)) age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
    assign ok = age_r[1];
    a_oen_follows: assert property (ok |-> DIO4_OEN_O == !(src_r != 3'h0 || inv_r))
        else $error("terminal 4 enable wrong");
    a_none_level: assert property (ok && src_r == 3'h0 |-> DIO4_O == inv_r)
        else $error("idle output level wrong");
    a_health_out: assert property (ok && src_r == 3'h1 |->
        DIO4_O == ((!$past(DRV_RUN_I) || !$past(DRV_TRIP_I)) ^ inv_r))
        else $error("health output wrong");
    a_trip_out: assert property (ok && src_r == 3'h2 |->
        DIO4_O == ($past(DRV_TRIP_I) ^ inv_r)) else $error("trip output wrong");
    a_run_out: assert property (ok && src_r == 3'h3 |->
        DIO4_O == ($past(DRV_RUN_I) ^ inv_r)) else $error("run output wrong");
    a_zero_out: assert property (ok && src_r == 3'h4 |-> DIO4_O ==
        (({16'h0, $past(DRV_FREQ_I)} * 32'h64 <
          {16'h0, $past(DRV_MAXSPD_I)}) ^ inv_r))
        else $error("zero speed output wrong");
    a_bresp_delay: assert property (AWVALID_I && AWREADY_O && WVALID_I &&
        WREADY_O |=> !BVALID_O ##1 BVALID_O) else $error("write answer late");
    a_rdata_hold: assert property (RVALID_O && !RREADY_I |=>
        RVALID_O && $stable(RDATA_O)) else $error("read data dropped");
endmodule
bind tic_top tic_top_asserts u_chk (.*);
